// >>> logic/pzg_map.svh
// offsets, field positions and reset values of the port zero pin control block
`ifndef PZG_MAP_SVH
`define PZG_MAP_SVH
`define PZG_PINS 8
`define PZG_ANALOG_MASK 8'hFF
`define PZG_OFF_DATA 8'h00
`define PZG_OFF_DIR 8'h04
`define PZG_OFF_AID 8'h08
`define PZG_OFF_STBY 8'h0C
`define PZG_OFF_RMW 8'h10
`define PZG_OFF_LEVEL 8'h14
`define PZG_STBY_SPL_BIT 0
`define PZG_STBY_FLOAT_BIT 1
`define PZG_RST_LATCH 1'b0
`define PZG_RST_DIR 1'b0
`define PZG_RST_AID 1'b0
`define PZG_RST_SPL 1'b0
`endif

// >>> logic/pzg_pkg.sv
// types shared by the port zero pin control block
package pzg_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pzg_wb_req_t;

  typedef struct packed {
    logic latch;
    logic dir;
    logic aid;
    logic periph_oe;
    logic periph_out;
    logic float_req;
    logic irq_en;
  } pzg_pin_ctl_t;

endpackage : pzg_pkg

// >>> logic/pzg_bit_reg.sv
// software-written register of per-pin control bits
module pzg_bit_reg #(
  parameter int W = 8,
  parameter logic RST_BIT = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic wr_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= {W{RST_BIT}};
    end else if (wr_i) begin
      q_o <= d_i;
    end
  end

endmodule : pzg_bit_reg

// >>> logic/pzg_pin_cell.sv
// one port pin: drive selection, standby float and input gating
module pzg_pin_cell #(
  parameter logic ANALOG = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control and pin
  input wire pzg_pkg::pzg_pin_ctl_t ctl_i,
  input wire logic pin_in_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic din_o
);
  import pzg_pkg::*;

  wire logic analog_block;
  wire logic float_block;
  wire logic nxt_oe;
  wire logic nxt_out;
  wire logic nxt_din;

  assign analog_block = ANALOG & ~ctl_i.aid;
  assign float_block = ctl_i.float_req & ~ctl_i.irq_en;
  assign nxt_oe = ~ctl_i.float_req & (ctl_i.periph_oe | ctl_i.dir);
  assign nxt_out = ctl_i.periph_oe ? ctl_i.periph_out : ctl_i.latch;
  assign nxt_din = pin_in_i & ~analog_block & ~float_block;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_oe_o <= 1'b0;
      pin_out_o <= 1'b0;
      din_o <= 1'b0;
    end else begin
      pin_oe_o <= nxt_oe;
      pin_out_o <= nxt_out;
      din_o <= nxt_din;
    end
  end

endmodule : pzg_pin_cell

// >>> logic/pzg_top.sv
// port zero pin control: wishbone registers, pin cells and checks
// Overview of operation
// - direction bit one makes the pin an output port
// - an output port pin drives its data latch bit
// - data writes update the latch; output pins show it one clock later
// - data reads of an output port pin return the latch
// - direction bit zero makes the pin an input port
// - writes to an input pin update the latch but do not drive
// - input pin: ordinary read gives pin level, read-modify-write read gives latch
// - peripheral output enable makes the pin drive the peripheral value
// - peripheral-driven pin: ordinary read gives level, read-modify-write gives latch
// - ordinary reads return the pin level even when a peripheral uses it
// - reset clears direction and analog disable bits
// - standby float forces high impedance and holds the input low
// - an enabled external interrupt keeps its input path open in standby float
// - without float select, standby leaves pins and drive unchanged
//
// Our own choices: the address map and the Wishbone register port.
`include "pzg_map.svh"
module pzg_top #(
  parameter int PINS = `PZG_PINS,
  parameter logic [7:0] ANALOG_MASK = `PZG_ANALOG_MASK
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire pzg_pkg::pzg_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // pins
  input wire logic [PINS-1:0] pin_in_i,
  output logic [PINS-1:0] pin_out_o,
  output logic [PINS-1:0] pin_oe_o,
  // peripherals sharing the pins
  input wire logic [PINS-1:0] periph_oe_i,
  input wire logic [PINS-1:0] periph_out_i,
  output logic [PINS-1:0] periph_in_o,
  // standby and external interrupts
  input wire logic standby_i,
  input wire logic [PINS-1:0] ext_irq_en_i
);
  import pzg_pkg::*;

  if (PINS < 1 || PINS > 8) begin : g_bad_pins
    $error("pzg_top: PINS must be 1 to 8");
  end

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction : hit

  function automatic logic [31:0] zext(input logic [PINS-1:0] v);
    return {{(32 - PINS){1'b0}}, v};
  endfunction : zext

  logic ack_ff;
  logic [31:0] dat_ff;
  logic [PINS-1:0] port_data_latch;
  logic [PINS-1:0] pin_direction_bits;
  logic [PINS-1:0] analog_input_disable_low;
  logic [0:0] standby_pin_float_select;
  pzg_pin_ctl_t ctl [PINS];

  // bus decode
  wire logic req = wb_i.cyc & wb_i.stb;
  wire logic wr_now = req & wb_i.we & ack_ff & wb_i.sel[0];
  wire logic sel_data = hit(wb_i.adr, `PZG_OFF_DATA);
  wire logic sel_dir = hit(wb_i.adr, `PZG_OFF_DIR);
  wire logic sel_aid = hit(wb_i.adr, `PZG_OFF_AID);
  wire logic sel_stby = hit(wb_i.adr, `PZG_OFF_STBY);
  wire logic sel_rmw = hit(wb_i.adr, `PZG_OFF_RMW);
  wire logic sel_level = hit(wb_i.adr, `PZG_OFF_LEVEL);
  wire logic wr_latch = wr_now & (sel_data | sel_rmw);
  wire logic wr_dir = wr_now & sel_dir;
  wire logic wr_aid = wr_now & sel_aid;
  wire logic wr_stby = wr_now & sel_stby;
  wire logic float_now = standby_i & standby_pin_float_select[0];

  // registers
  pzg_bit_reg #(.W(PINS), .RST_BIT(`PZG_RST_LATCH)) u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_latch),
    .d_i(wb_i.dat[PINS-1:0]),
    .q_o(port_data_latch)
  );

  pzg_bit_reg #(.W(PINS), .RST_BIT(`PZG_RST_DIR)) u_dir (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_dir),
    .d_i(wb_i.dat[PINS-1:0]),
    .q_o(pin_direction_bits)
  );

  pzg_bit_reg #(.W(PINS), .RST_BIT(`PZG_RST_AID)) u_aid (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_aid),
    .d_i(wb_i.dat[PINS-1:0]),
    .q_o(analog_input_disable_low)
  );

  pzg_bit_reg #(.W(1), .RST_BIT(`PZG_RST_SPL)) u_spl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_stby),
    .d_i(wb_i.dat[`PZG_STBY_SPL_BIT]),
    .q_o(standby_pin_float_select)
  );

  // pin cells, one per pin
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign ctl[i] = '{latch: port_data_latch[i], dir: pin_direction_bits[i],
                      aid: analog_input_disable_low[i], periph_oe: periph_oe_i[i],
                      periph_out: periph_out_i[i], float_req: float_now,
                      irq_en: ext_irq_en_i[i]};
    pzg_pin_cell #(.ANALOG(ANALOG_MASK[i])) u_cell (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctl_i(ctl[i]),
      .pin_in_i(pin_in_i[i]),
      .pin_out_o(pin_out_o[i]),
      .pin_oe_o(pin_oe_o[i]),
      .din_o(periph_in_o[i])
    );
  end

  // read values
  wire logic [PINS-1:0] out_port = pin_direction_bits & ~periph_oe_i;
  wire logic [PINS-1:0] port_rd = (port_data_latch & out_port) | (periph_in_o & ~out_port);
  wire logic [31:0] stby_word = (32'(standby_pin_float_select[0]) << `PZG_STBY_SPL_BIT)
                              | (32'(float_now) << `PZG_STBY_FLOAT_BIT);
  wire logic [31:0] rd_word = sel_data ? zext(port_rd) :
                              sel_rmw ? zext(port_data_latch) :
                              sel_dir ? zext(pin_direction_bits) :
                              sel_aid ? zext(analog_input_disable_low) :
                              sel_stby ? stby_word :
                              sel_level ? zext(periph_in_o) : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        dat_ff <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // helper state for the checks
  logic [PINS-1:0] out_port_d;
  logic [PINS-1:0] in_port_d;
  logic [PINS-1:0] periph_d;
  logic [PINS-1:0] periph_out_d;
  logic [PINS-1:0] keep_in_d;
  logic [PINS-1:0] pin_in_d;
  logic [PINS-1:0] latch_d;
  logic [PINS-1:0] wdat_d;
  logic float_d;
  logic hold_d;
  logic [PINS-1:0] hold_oe_d;

  always_ff @(posedge clk_i) begin
    out_port_d <= out_port;
    in_port_d <= ~pin_direction_bits & ~periph_oe_i;
    periph_d <= periph_oe_i;
    periph_out_d <= periph_out_i;
    keep_in_d <= ext_irq_en_i & (analog_input_disable_low | ~ANALOG_MASK[PINS-1:0]);
    pin_in_d <= pin_in_i;
    latch_d <= port_data_latch;
    wdat_d <= wb_i.dat[PINS-1:0];
    float_d <= float_now;
    hold_d <= standby_i & ~standby_pin_float_select[0];
    hold_oe_d <= pin_direction_bits | periph_oe_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_latch_write;
    wr_latch;
  endsequence

  sequence s_data_read;
    req && !ack_ff && !wb_i.we && sel_data;
  endsequence

  sequence s_rmw_read;
    req && !ack_ff && !wb_i.we && sel_rmw;
  endsequence

  sequence s_level_read;
    req && !ack_ff && !wb_i.we && sel_level;
  endsequence

  sequence s_stby_read;
    req && !ack_ff && !wb_i.we && sel_stby;
  endsequence

  AST_OUT_DRIVES_LATCH: assert property (
    !$past(float_now) |-> ((pin_oe_o & out_port_d) == out_port_d)
      && (((pin_out_o ^ latch_d) & out_port_d) == '0))
    else $error("output port pin not driving its latch bit");

  AST_WRITE_REACHES_PIN: assert property (
    s_latch_write |=> (port_data_latch == wdat_d) ##1
      (float_d || (((pin_out_o ^ latch_d) & out_port_d) == '0)))
    else $error("latch write not stored or not shown on output pins");

  AST_READ_OUT_LATCH: assert property (
    s_data_read |=> ((wb_dat_o[PINS-1:0] & out_port_d) == (latch_d & out_port_d)))
    else $error("data read of output port pin not the latch");

  AST_INPUT_NOT_DRIVEN: assert property (
    (pin_oe_o & in_port_d) == '0)
    else $error("input port pin is driven");

  AST_READ_IN_LEVEL: assert property (
    s_data_read |=> ((wb_dat_o[PINS-1:0] & ~out_port_d) == ($past(periph_in_o) & ~out_port_d)))
    else $error("data read of input pin not the pin level");

  AST_RMW_LATCH: assert property (
    s_rmw_read |=> (wb_dat_o[PINS-1:0] == latch_d))
    else $error("read-modify-write read not the latch");

  AST_PERIPH_DRIVES: assert property (
    !float_d |-> ((pin_oe_o & periph_d) == periph_d)
      && (((pin_out_o ^ periph_out_d) & periph_d) == '0))
    else $error("peripheral output not on its pin");

  AST_RESET_CLEARS: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (pin_direction_bits == '0) && (analog_input_disable_low == '0) && (pin_oe_o == '0))
    else $error("reset left direction or analog disable set");

  AST_FLOAT_HIZ_LOW: assert property (
    float_d |-> (pin_oe_o == '0) && ((periph_in_o & ~keep_in_d) == '0))
    else $error("standby float pin driven or input not held low");

  AST_IRQ_PATH_OPEN: assert property (
    float_d |-> ((periph_in_o & keep_in_d) == (pin_in_d & keep_in_d)))
    else $error("enabled interrupt input blocked in standby");

  AST_STANDBY_HOLD: assert property (
    hold_d |-> (pin_oe_o == hold_oe_d))
    else $error("standby without float select changed drive");

  AST_ACK_ONE_CYCLE: assert property (
    req && !ack_ff |=> ack_ff ##1 !ack_ff)
    else $error("bus answer not a single cycle");

  AST_ACK_NEEDS_REQ: assert property (
    ack_ff |-> $past(req && !ack_ff))
    else $error("bus answer without a request");

  AST_DIR_WRITE: assert property (
    wr_dir |=> (pin_direction_bits == $past(wb_i.dat[PINS-1:0])))
    else $error("direction write not stored");

  AST_DIR_KEEPS: assert property (
    !wr_dir |=> $stable(pin_direction_bits))
    else $error("direction bits changed without a write");

  AST_AID_WRITE: assert property (
    wr_aid |=> (analog_input_disable_low == $past(wb_i.dat[PINS-1:0])))
    else $error("analog disable write not stored");

  AST_SPL_WRITE: assert property (
    wr_stby |=> (standby_pin_float_select[0] == $past(wb_i.dat[`PZG_STBY_SPL_BIT])))
    else $error("float select write not stored");

  AST_LATCH_KEEPS: assert property (
    !wr_latch |=> $stable(port_data_latch))
    else $error("latch changed without a write");

  AST_OUT_SOURCE: assert property (
    pin_out_o == ((periph_out_d & periph_d) | (latch_d & ~periph_d)))
    else $error("pin value from the wrong source");

  AST_INPUT_GATED: assert property (
    !float_d |-> (periph_in_o == (pin_in_d & ($past(analog_input_disable_low) | ~ANALOG_MASK[PINS-1:0]))))
    else $error("pin input wrongly gated");

  AST_LEVEL_READ: assert property (
    s_level_read |=> (wb_dat_o[PINS-1:0] == $past(periph_in_o)))
    else $error("level read not the gated pin level");

  AST_STBY_READ: assert property (
    s_stby_read |=> (wb_dat_o[`PZG_STBY_FLOAT_BIT] == $past(float_now))
      && (wb_dat_o[`PZG_STBY_SPL_BIT] == $past(standby_pin_float_select[0])))
    else $error("standby control read wrong");

  AST_READ_UPPER_ZERO: assert property (
    req && !ack_ff && !wb_i.we && !sel_stby |=> (wb_dat_o[31:PINS] == '0))
    else $error("unused read bits not zero");

endmodule : pzg_top

// >>> tb/pzg_pin_env.sv
// outside world of the port pins: port drive, outside driver, floating lines
module pzg_pin_env (
  // clock
  input wire logic clk_i,
  // port drive
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  // outside driver
  input wire logic [7:0] ext_oe_i,
  input wire logic [7:0] ext_val_i,
  // resolved level
  output logic [7:0] pin_in_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_ff = 8'h00;
  always_ff @(posedge clk_i) begin
    last_ff <= pin_in_o;
  end
  // a line nobody drives toggles, so no stale level can pass for a driven one
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_oe_i & ext_val_i) | (~pin_oe_i & ~ext_oe_i & ~last_ff);
endmodule : pzg_pin_env

// >>> tb/tb.sv
// testbench of the port zero pin control block with a cycle model
`include "pzg_map.svh"
module tb;
  import pzg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pzg_wb_req_t wb_i = '0;
  logic wb_ack_o, chk_on = 1'b0, fl, standby_i = 1'b0;
  logic [31:0] wb_dat_o, rd_exp, q, seed = 32'he770;
  logic [7:0] pin_in_i, pin_out_o, pin_oe_o, periph_in_o, ext_oe, ext_val;
  logic [7:0] periph_oe_i = 8'h00, periph_out_i = 8'h00, ext_irq_en_i = 8'h00;
  logic [7:0] m_latch, m_dir, m_aid, e_oe, e_out, e_in;
  logic m_spl;
  logic [7:0] adrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int miscompares = 0, comparisons = 0;
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  pzg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .periph_oe_i(periph_oe_i),
    .periph_out_i(periph_out_i), .periph_in_o(periph_in_o), .standby_i(standby_i), .ext_irq_en_i(ext_irq_en_i));
  pzg_pin_env u_env (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_oe_i(ext_oe),
    .ext_val_i(ext_val), .pin_in_o(pin_in_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  function automatic logic [31:0] rdval(input logic [7:0] a);
    logic [7:0] own;
    own = m_dir & ~periph_oe_i;
    case (a)
      `PZG_OFF_DATA: return {24'h0, (own & m_latch) | (~own & e_in)};
      `PZG_OFF_DIR: return {24'h0, m_dir};
      `PZG_OFF_AID: return {24'h0, m_aid};
      `PZG_OFF_STBY: return {30'h0, fl, m_spl};
      `PZG_OFF_RMW: return {24'h0, m_latch};
      `PZG_OFF_LEVEL: return {24'h0, e_in};
      default: return 32'h0;
    endcase
  endfunction : rdval
  // cycle model: checks the last edge, then predicts the next one
  always @(negedge clk_i) begin
    if (chk_on) begin
      chk("pin_oe", {24'h0, e_oe}, {24'h0, pin_oe_o});
      chk("pin_out", {24'h0, e_out}, {24'h0, pin_out_o});
      chk("periph_in", {24'h0, e_in}, {24'h0, periph_in_o});
    end
    fl = standby_i & m_spl;
    if (wb_i.cyc && wb_i.stb && !wb_ack_o) rd_exp = rdval(wb_i.adr);
    if (rst_i) begin
      {m_latch, m_dir, m_aid, m_spl, e_oe, e_out, e_in} = '0;
    end else begin
      e_oe = {8{!fl}} & (periph_oe_i | m_dir);
      e_out = (periph_oe_i & periph_out_i) | (~periph_oe_i & m_latch);
      e_in = pin_in_i & ~(`PZG_ANALOG_MASK & ~m_aid) & ~({8{fl}} & ~ext_irq_en_i);
      if (wb_ack_o && wb_i.we) begin
        case (wb_i.adr)
          `PZG_OFF_DATA, `PZG_OFF_RMW: m_latch = wb_i.dat[7:0];
          `PZG_OFF_DIR: m_dir = wb_i.dat[7:0];
          `PZG_OFF_AID: m_aid = wb_i.dat[7:0];
          `PZG_OFF_STBY: m_spl = wb_i.dat[0];
          default: ;
        endcase
      end
    end
    chk_on = 1'b1;
  end
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      close_out();
    end
    q = wb_dat_o;
    if (!we) chk("read", rd_exp, q);
    wb_i <= '0;
  endtask : bus
  initial begin
    ext_oe = 8'h00;
    ext_val = 8'h00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[i]) bus(1'b0, adrs[i], 8'h00);
    for (int i = 0; i < 500; i++) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      periph_oe_i <= seed[7:0] & seed[15:8];
      periph_out_i <= seed[23:16];
      ext_oe <= seed[31:24];
      ext_val <= seed[15:8];
      ext_irq_en_i <= seed[23:16] ^ seed[7:0];
      standby_i <= seed[3] & seed[9];
      bus(1'b1, adrs[seed[2:0] % 7], seed[31:24] ^ seed[7:0]);
      bus(1'b0, adrs[seed[12:10] % 7], 8'h00);
    end
    close_out();
  end
endmodule : tb
